// *** rtl/if_cal_regs.vh ***
// Constants for the IF filter calibration sequencer and its register map.
`ifndef IF_CAL_REGS_VH
`define IF_CAL_REGS_VH

// ****************************************************************
// Serial register indices and fields
// ****************************************************************
`define REG_MUX_IDX          4'h0
`define REG_IF_IDX           4'h4
`define REG_CAL_IDX          4'h5
`define REG_READBACK_IDX     4'h7
`define MUX_SEL_HI           31
`define MUX_SEL_LO           29
`define BW_SEL_HI            31
`define BW_SEL_LO            30
`define CAL_COARSE_BIT       4
`define CAL_FINE_BIT         5
`define ADJUST_HI            19
`define ADJUST_LO            14
`define READBACK_EN_BIT      8
`define MUX_SEL_CAL_DONE     3'h5
`define REG_RESET            32'h00000000

// ****************************************************************
// Bus offsets
// ****************************************************************
`define OFF_IRQ_STATUS       8'h40
`define OFF_IRQ_MASK         8'h44
`define OFF_CAL_STATUS       8'h48
`define IRQ_CAL_DONE_BIT     0
`define IRQ_BUSY_ACCESS_BIT  1

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ              50
`define CAL_COARSE_US        200
`define CAL_FINE_TOTAL_US    5200
`define SERIAL_READ_CYCLES   5'd18
`define TRIM_MID             6'h20

`endif

// *** rtl/if_filter_calibration_sequencer.v ***
// IF filter coarse and fine calibration sequencer with APB registers.
//
// Notes on behaviour
// - Register 5 write starts calibration, self-running.
// - Coarse calibration lasts about 200 us.
// - Fine request runs coarse first, 5.2 ms total.
// - Status pin shows completion when selected.
// - Fine result readable over the serial port.
// - Six-bit manual adjust loads the filter trim.
// - Serial writes MSB first, latched by load.
// - Readback takes 18 clocks with load high.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "if_cal_regs.vh"
module if_filter_calibration_sequencer
#(
    parameter COARSE_CYCLES = `CAL_COARSE_US * `CLK_MHZ,
    parameter FINE_CYCLES   = (`CAL_FINE_TOTAL_US - `CAL_COARSE_US) *
                              `CLK_MHZ
)
(
    input  wire        CLK_I,
    input  wire        RST_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [7:0]  PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    input  wire        SCLK_I,
    input  wire        SDATA_I,
    input  wire        SERIAL_LOAD_STROBE_I,
    output wire        SERIAL_READ_OUT_O,
    output wire        SERIAL_READ_OUT_OE_O,
    input  wire        FILTER_HIGH_I,
    output reg  [5:0]  FILTER_TRIM_O,
    output reg  [1:0]  FILTER_BANDWIDTH_SELECT_O,
    output reg         STATUS_MUX_PIN_O,
    output reg         IRQ_O
);

    localparam S_IDLE   = 2'h0;
    localparam S_COARSE = 2'h1;
    localparam S_FINE   = 2'h2;
    // Step lengths are cut to the counter width; the defaults fit in it.
    localparam integer COARSE_DIV  = COARSE_CYCLES / 6;
    localparam integer FINE_DIV    = FINE_CYCLES / 64;
    localparam [17:0]  COARSE_STEP = COARSE_DIV[17:0];
    localparam [17:0]  FINE_STEP   = FINE_DIV[17:0];

    reg  [1:0]  state;
    reg  [17:0] count;
    reg  [2:0]  sar_bit;
    reg  [5:0]  fine_steps;
    reg         fine_req;
    reg  [5:0]  fine_result;
    reg         cal_complete;
    reg  [31:0] reg_mux;
    reg  [31:0] reg_if;
    reg  [31:0] reg_cal;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_mask;
    reg  [1:0]  high_sync;
    reg  [31:0] next_prdata;
    reg         next_slverr;
    wire        ser_wr;
    wire [31:0] ser_data;
    wire        apb_access;
    wire        apb_write;
    wire        wr;
    wire [31:0] wr_data;
    wire        busy;
    wire        accept;
    wire        start;
    wire        done_evt;
    wire        read_status;
    wire        mapped_reg;

    serial_reg_port u_serial
    (
        .clk_i           (CLK_I),
        .rst_i           (RST_I),
        .sclk_i          (SCLK_I),
        .sdata_i         (SDATA_I),
        .load_i          (SERIAL_LOAD_STROBE_I),
        .readback_word_i ({10'h000, fine_result}),
        .wr_o            (ser_wr),
        .wr_data_o       (ser_data),
        .read_out_o      (SERIAL_READ_OUT_O),
        .read_out_oe_o   (SERIAL_READ_OUT_OE_O)
    );

    // ****************************************************************
    // Register write path
    // ****************************************************************
    // A bus access waits while a serial latch is in flight, so neither
    // write is lost when both arrive together.
    assign apb_access  = PSEL_I & PENABLE_I & ~PREADY_O & ~ser_wr;
    assign mapped_reg  = (PADDR_I[7:6] == 2'h0) && (PADDR_I[1:0] == 2'h0);
    assign apb_write   = apb_access & PWRITE_I & mapped_reg;
    assign wr          = ser_wr | apb_write;
    assign wr_data     = ser_wr ? ser_data :
                         {PWDATA_I[31:4], PADDR_I[5:2]};
    assign busy        = (state != S_IDLE);
    assign accept      = wr & ~busy;
    assign start       = accept && wr_data[3:0] == `REG_CAL_IDX &&
                         (wr_data[`CAL_COARSE_BIT] | wr_data[`CAL_FINE_BIT]);
    assign read_status = apb_access & ~PWRITE_I &
                         PADDR_I == `OFF_IRQ_STATUS;

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            reg_mux <= `REG_RESET;
            reg_if  <= `REG_RESET;
            reg_cal <= `REG_RESET;
        end
        else if (accept)
        begin
            case (wr_data[3:0])
                `REG_MUX_IDX: reg_mux <= wr_data;
                `REG_IF_IDX:  reg_if  <= wr_data;
                `REG_CAL_IDX: reg_cal <= wr_data;
                default:      reg_mux <= reg_mux;
            endcase
        end
    end

    // ****************************************************************
    // Calibration sequencer
    // ****************************************************************
    assign done_evt = (state == S_COARSE && count == 18'h0 &&
                       sar_bit == 3'h0 && !fine_req) ||
                      (state == S_FINE && count == 18'h0 &&
                       fine_steps == 6'h00);

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state         <= S_IDLE;
            count         <= 18'h0;
            sar_bit       <= 3'h0;
            fine_steps    <= 6'h00;
            fine_req      <= 1'b0;
            fine_result   <= 6'h00;
            cal_complete  <= 1'b1;
            FILTER_TRIM_O <= `TRIM_MID;
            high_sync     <= 2'h0;
        end
        else
        begin
            high_sync <= {high_sync[0], FILTER_HIGH_I};
            case (state)
                S_IDLE:
                begin
                    if (start)
                    begin
                        // A fine request always begins with coarse.
                        state         <= S_COARSE;
                        fine_req      <= wr_data[`CAL_FINE_BIT];
                        count         <= COARSE_STEP - 18'h1;
                        sar_bit       <= 3'h5;
                        FILTER_TRIM_O <= `TRIM_MID;
                        cal_complete  <= 1'b0;
                    end
                    else if (accept && wr_data[3:0] == `REG_CAL_IDX)
                        FILTER_TRIM_O <=
                            wr_data[`ADJUST_HI:`ADJUST_LO];
                end
                S_COARSE:
                begin
                    if (count != 18'h0)
                        count <= count - 18'h1;
                    else
                    begin
                        // Successive approximation, one trim bit a step.
                        if (high_sync[1])
                            FILTER_TRIM_O[sar_bit] <= 1'b0;
                        if (sar_bit != 3'h0)
                        begin
                            sar_bit <= sar_bit - 3'h1;
                            FILTER_TRIM_O[sar_bit - 3'h1] <= 1'b1;
                            count <= COARSE_STEP - 18'h1;
                        end
                        else if (fine_req)
                        begin
                            state      <= S_FINE;
                            fine_steps <= 6'h3F;
                            count      <= FINE_STEP - 18'h1;
                        end
                        else
                        begin
                            state        <= S_IDLE;
                            cal_complete <= 1'b1;
                        end
                    end
                end
                S_FINE:
                begin
                    if (count != 18'h0)
                        count <= count - 18'h1;
                    else
                    begin
                        // Tracking step; the code saturates at both ends.
                        if (high_sync[1] && FILTER_TRIM_O != 6'h00)
                            FILTER_TRIM_O <= FILTER_TRIM_O - 6'h01;
                        else if (!high_sync[1] && FILTER_TRIM_O != 6'h3F)
                            FILTER_TRIM_O <= FILTER_TRIM_O + 6'h01;
                        count      <= FINE_STEP - 18'h1;
                        fine_steps <= fine_steps - 6'h01;
                        if (fine_steps == 6'h00)
                        begin
                            state        <= S_IDLE;
                            fine_result  <= FILTER_TRIM_O;
                            cal_complete <= 1'b1;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Interrupts, status pin and bus answer
    // ****************************************************************
    always @*
    begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        if (mapped_reg)
        begin
            case (PADDR_I[5:2])
                `REG_MUX_IDX: next_prdata = reg_mux;
                `REG_IF_IDX:  next_prdata = reg_if;
                `REG_CAL_IDX: next_prdata = reg_cal;
                default:      next_slverr = 1'b1;
            endcase
        end
        else if (PADDR_I == `OFF_IRQ_STATUS)
            next_prdata = {30'h00000000, irq_status};
        else if (PADDR_I == `OFF_IRQ_MASK)
            next_prdata = {30'h00000000, irq_mask};
        else if (PADDR_I == `OFF_CAL_STATUS)
            next_prdata = {8'h00, 2'h0, fine_result,
                           2'h0, FILTER_TRIM_O, 6'h00,
                           cal_complete, busy};
        else
            next_slverr = 1'b1;
    end

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            PRDATA_O                  <= 32'h00000000;
            PREADY_O                  <= 1'b0;
            PSLVERR_O                 <= 1'b0;
            irq_status                <= 2'h0;
            irq_mask                  <= 2'h0;
            IRQ_O                     <= 1'b0;
            STATUS_MUX_PIN_O          <= 1'b0;
            FILTER_BANDWIDTH_SELECT_O <= 2'h0;
        end
        else
        begin
            PREADY_O  <= apb_access;
            PSLVERR_O <= apb_access & next_slverr;
            if (apb_access && !PWRITE_I)
                PRDATA_O <= next_prdata;
            if (apb_access && PWRITE_I && PADDR_I == `OFF_IRQ_MASK)
                irq_mask <= PWDATA_I[1:0];
            // A new event in the clearing read's cycle still stays set.
            irq_status <= (read_status ? 2'h0 : irq_status) |
                          {wr & busy, done_evt};
            IRQ_O <= |(irq_status & irq_mask);
            STATUS_MUX_PIN_O <= (reg_mux[`MUX_SEL_HI:`MUX_SEL_LO] ==
                                 `MUX_SEL_CAL_DONE) &
                                cal_complete;
            FILTER_BANDWIDTH_SELECT_O <= reg_if[`BW_SEL_HI:`BW_SEL_LO];
        end
    end
endmodule

// *** rtl/serial_reg_port.v ***
// Three-wire serial register port with write latching and readback.
`timescale 1ns/1ns
module serial_reg_port
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        sclk_i,
    input  wire        sdata_i,
    input  wire        load_i,
    input  wire [15:0] readback_word_i,
    output reg         wr_o,
    output reg  [31:0] wr_data_o,
    output reg         read_out_o,
    output reg         read_out_oe_o
);
`include "if_cal_regs.vh"

    reg  [2:0]  sclk_sync;
    reg  [2:0]  load_sync;
    reg  [1:0]  data_sync;
    reg  [31:0] shift;
    reg  [15:0] rb_shift;
    reg  [4:0]  rb_count;
    reg         rb_active;
    wire        sclk_rise;
    wire        load_rise;

    // Bit 0 of each chain is the first stage; only bit 1 reads it.
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    assign load_rise = load_sync[1] & ~load_sync[2];

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sclk_sync     <= 3'h0;
            load_sync     <= 3'h0;
            data_sync     <= 2'h0;
            shift         <= 32'h00000000;
            rb_shift      <= 16'h0000;
            rb_count      <= 5'h00;
            rb_active     <= 1'b0;
            wr_o          <= 1'b0;
            wr_data_o     <= 32'h00000000;
            read_out_o    <= 1'b0;
            read_out_oe_o <= 1'b0;
        end
        else
        begin
            sclk_sync <= {sclk_sync[1:0], sclk_i};
            load_sync <= {load_sync[1:0], load_i};
            data_sync <= {data_sync[0], sdata_i};
            wr_o      <= 1'b0;
            if (sclk_rise && !rb_active)
                shift <= {shift[30:0], data_sync[1]};
            if (load_rise)
            begin
                wr_o      <= 1'b1;
                wr_data_o <= shift;
                if (shift[3:0] == `REG_READBACK_IDX &&
                    shift[`READBACK_EN_BIT])
                begin
                    rb_active <= 1'b1;
                    rb_count  <= 5'h00;
                    rb_shift  <= readback_word_i;
                end
            end
            else if (rb_active && !load_sync[1])
            begin
                rb_active     <= 1'b0;
                read_out_oe_o <= 1'b0;
            end
            else if (rb_active && sclk_rise)
            begin
                // First edge gives a dummy bit, then 16 data bits MSB first.
                rb_count <= rb_count + 5'd1;
                if (rb_count == 5'h00)
                begin
                    read_out_oe_o <= 1'b1;
                    read_out_o    <= 1'b0;
                end
                else if (rb_count < `SERIAL_READ_CYCLES - 5'd1)
                begin
                    read_out_o <= rb_shift[15];
                    rb_shift   <= {rb_shift[14:0], 1'b0};
                end
                else
                begin
                    read_out_oe_o <= 1'b0;
                    rb_active     <= 1'b0;
                end
            end
        end
    end
endmodule

// *** test/if_cal_monitor.sv ***
// Port checker for the IF filter calibration sequencer.
`timescale 1ns/1ns
module if_cal_monitor
#(
    parameter COARSE_CYCLES = 10000,
    parameter FINE_CYCLES   = 250000
)
(
    input wire        CLK_I,
    input wire        RST_I,
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [7:0]  PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire        PREADY_O,
    input wire        PSLVERR_O,
    input wire [5:0]  FILTER_TRIM_O,
    input wire        STATUS_MUX_PIN_O,
    input wire        IRQ_O
);
    // ********************************
    // Helper state
    // ********************************
    // Bounds allow ten percent slack, since run times are typical only.
    localparam int CMIN = COARSE_CYCLES - COARSE_CYCLES / 10;
    localparam int TSUM = COARSE_CYCLES + FINE_CYCLES;
    logic [19:0] low_cnt;
    logic        ran;
    logic        fine_req;
    logic        mask0;
    logic [5:0]  adj;
    wire done = PSEL_I && PENABLE_I && PREADY_O && !PSLVERR_O;
    wire wr5  = done && PWRITE_I && PADDR_I == 8'h14 && STATUS_MUX_PIN_O;
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            low_cnt <= 20'h00000;
            ran <= 1'b0;
            fine_req <= 1'b0;
            mask0 <= 1'b0;
            adj <= 6'h00;
        end
        else
        begin
            low_cnt <= STATUS_MUX_PIN_O ? 20'h00000 : low_cnt + 20'h00001;
            if ($fell(STATUS_MUX_PIN_O))
                ran <= 1'b1;
            else if (STATUS_MUX_PIN_O)
                ran <= 1'b0;
            if (wr5 && PWDATA_I[5])
                fine_req <= 1'b1;
            else if ($rose(STATUS_MUX_PIN_O))
                fine_req <= 1'b0;
            if (done && PWRITE_I && PADDR_I == 8'h44)
                mask0 <= PWDATA_I[0];
            if (wr5)
                adj <= PWDATA_I[19:14];
        end
    end
    // ********************************
    // Assertions
    // ********************************
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence start_s; wr5 && PWDATA_I[5:4] != 2'b00; endsequence
    sequence end_s; $rose(STATUS_MUX_PIN_O) && ran; endsequence
    sequence fine_end_s; $rose(STATUS_MUX_PIN_O) && ran && fine_req;
    endsequence
    sequence irq_end_s; $rose(STATUS_MUX_PIN_O) && ran && mask0; endsequence
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held longer than one cycle");
    ready_wait_a: assert property ($rose(PSEL_I && PENABLE_I) |->
        ##[1:8] PREADY_O) else $error("no ready within eight cycles");
    err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    unmapped_err_a: assert property (PSEL_I && PENABLE_I && PREADY_O &&
        PADDR_I == 8'h0C |-> PSLVERR_O) else $error("unmapped accepted");
    start_drop_a: assert property
        (start_s |-> ##[1:3] !STATUS_MUX_PIN_O)
        else $error("complete kept after start");
    cal_length_a: assert property
        (end_s |-> low_cnt >= CMIN && low_cnt <= TSUM + TSUM / 10)
        else $error("calibration length out of range");
    fine_length_a: assert property
        (fine_end_s |-> low_cnt >= TSUM - TSUM / 10)
        else $error("fine calibration too short");
    done_irq_a: assert property (irq_end_s |-> ##[0:3] IRQ_O)
        else $error("no interrupt at calibration end");
    trim_load_a: assert property
        (wr5 && PWDATA_I[5:4] == 2'b00 |-> ##[1:3] FILTER_TRIM_O == adj)
        else $error("manual adjust not loaded");
endmodule
bind if_filter_calibration_sequencer if_cal_monitor
    #(.COARSE_CYCLES(COARSE_CYCLES), .FINE_CYCLES(FINE_CYCLES)) u_monitor
    (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
     .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
     .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
     .FILTER_TRIM_O(FILTER_TRIM_O), .STATUS_MUX_PIN_O(STATUS_MUX_PIN_O),
     .IRQ_O(IRQ_O));

// *** test/serial_host_model.sv ***
// Host model that drives the three-wire serial register port.
`timescale 1ns/1ns
module serial_host_model
(
    input  wire  clk_i,
    input  wire  read_i,
    input  wire  read_oe_i,
    output logic sclk_o = 1'b0,
    output logic sdata_o = 1'b0,
    output logic load_o = 1'b0
);
    // ********************************
    // Transfers
    // ********************************
    // Each serial level is held four cycles so the input sync sees it.
    task automatic half;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic send(input logic [31:0] w, input logic keep);
        for (int i = 31; i >= 0; i--)
        begin
            sdata_o <= w[i];
            half();
            sclk_o <= 1'b1;
            half();
            sclk_o <= 1'b0;
        end
        half();
        load_o <= 1'b1;
        sdata_o <= ~w[0];
        half();
        if (!keep)
        begin
            load_o <= 1'b0;
            half();
        end
    endtask
    task automatic readback(output logic [15:0] v, output logic ok);
        ok = 1'b1;
        send(32'h00000107, 1'b1);
        for (int k = 1; k <= 18; k++)
        begin
            sclk_o <= 1'b1;
            half();
            if (k >= 2 && k <= 17)
                v = {v[14:0], read_i};
            ok = ok & (read_oe_i === (k < 18));
            sclk_o <= 1'b0;
            half();
        end
        load_o <= 1'b0;
        half();
    endtask
endmodule

// *** test/tb_if_filter_calibration_sequencer.sv ***
// Self-checking bench for the IF filter calibration sequencer.
`timescale 1ns/1ns
module tb_if_filter_calibration_sequencer;
    localparam int C = 60;
    localparam int F = 640;
    localparam logic [5:0] TGT = 6'h2D;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    wire  [31:0] prdata;
    wire         pready, pslverr, sclk, sdata, load, rdo, rdo_oe, pin, irq;
    wire  [5:0]  trim;
    wire  [1:0]  bw;
    // The filter is modelled as a comparator against a fixed centre code.
    wire         fhigh = trim > TGT;
    int          checks = 0;
    int          err_count = 0;
    int          cyc = 0;
    int          lowc = 0;
    logic [5:0]  fine;
    if_filter_calibration_sequencer #(.COARSE_CYCLES(C), .FINE_CYCLES(F))
    i_dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SCLK_I(sclk), .SDATA_I(sdata), .SERIAL_LOAD_STROBE_I(load),
        .SERIAL_READ_OUT_O(rdo), .SERIAL_READ_OUT_OE_O(rdo_oe),
        .FILTER_HIGH_I(fhigh), .FILTER_TRIM_O(trim),
        .FILTER_BANDWIDTH_SELECT_O(bw), .STATUS_MUX_PIN_O(pin),
        .IRQ_O(irq));
    serial_host_model host (.clk_i(clk), .read_i(rdo), .read_oe_i(rdo_oe),
        .sclk_o(sclk), .sdata_o(sdata), .load_o(load));
    // ********************************
    // Shared tasks
    // ********************************
    initial
    begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        lowc <= (pin === 1'b1) ? 0 : lowc + 1;
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic c, input string m);
        checks++;
        if (c !== 1'b1)
        begin
            err_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    function automatic logic near(input logic [5:0] v);
        return 6'(v - TGT + 6'h01) <= 6'h02;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
    endtask
    task automatic wait_cal;
        while (pin !== 1'b1)
            @(posedge clk);
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_idle;
        logic [31:0] r;
        logic        e;
        rd(8'h48, r);
        chk(r === 32'h00002002, "idle status");
        chk(pin === 1'b0, "status pin not selected");
        apb(1'b0, 8'h0C, 32'h00000000, r, e);
        chk(e === 1'b1 && irq === 1'b0, "unmapped read accepted");
    endtask
    task automatic t_coarse;
        logic [31:0] r;
        wr(8'h00, 32'hA0000000);
        wr(8'h44, 32'h00000003);
        chk(pin === 1'b1, "complete not shown");
        host.send(32'h00000015, 1'b0);
        chk(pin === 1'b0, "complete during coarse run");
        wait_cal();
        chk(lowc >= C - C / 10 && lowc <= C + C / 10 + 4,
            "coarse time");
        chk(irq === 1'b1, "no done interrupt");
        rd(8'h40, r);
        chk(r === 32'h00000001, "irq status");
        @(posedge clk);
        chk(irq === 1'b0, "irq kept after read");
        rd(8'h48, r);
        chk(near(r[13:8]) && r[1:0] === 2'b10, "coarse trim");
    endtask
    task automatic t_fine;
        logic [31:0] r;
        wr(8'h14, 32'h00000025);
        wr(8'h10, 32'h80000004);
        chk(pin === 1'b0, "complete during fine run");
        wait_cal();
        chk(lowc >= (C + F) * 9 / 10 &&
            lowc <= (C + F) * 11 / 10, "fine time");
        rd(8'h40, r);
        chk(r === 32'h00000003 && bw === 2'b00, "busy access");
        rd(8'h48, r);
        fine = r[21:16];
        chk(near(r[21:16]) && r[0] === 1'b0, "fine result");
    endtask
    task automatic t_readback;
        logic [15:0] v;
        logic        ok;
        host.readback(v, ok);
        chk(ok === 1'b1, "read enable timing");
        chk(v === {10'h000, fine}, "readback word");
    endtask
    task automatic t_adjust;
        logic [5:0] v6;
        wr(8'h10, 32'h80000004);
        repeat (2) @(posedge clk);
        chk(bw === 2'b10, "bandwidth select");
        for (int i = 0; i < 2; i++)
        begin
            v6 = i ? fine : 6'h0B;
            wr(8'h14, {12'h000, v6, 14'h0005});
            @(posedge clk);
            chk(trim === v6 && pin === 1'b1, "manual adjust");
        end
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_idle();
        t_coarse();
        t_fine();
        t_readback();
        t_adjust();
        report_and_stop();
    end
endmodule
